/* File: design/libce_pkg.sv */
// Constants for the loop, increment, branch and call execution block.
// Assumes a 20 MHz core clock and twelve clocks to a machine cycle.
package libce_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int MCYCLE_NS = 600;
	localparam int CLKS_PER_MCYCLE = MCYCLE_NS / CLK_PERIOD_NS;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;
	localparam logic [7:0] OPM_REG = 8'hf8;
	localparam logic [7:0] OPM_IND = 8'hfe;
	localparam logic [7:0] OP_DECREMENT_BRANCH_NONZERO_R = 8'hd8;
	localparam logic [7:0] OP_DECREMENT_BRANCH_NONZERO_D = 8'hd5;
	localparam logic [7:0] OP_INC_A = 8'h04;
	localparam logic [7:0] OP_INC_R = 8'h08;
	localparam logic [7:0] OP_INC_D = 8'h05;
	localparam logic [7:0] OP_INC_I = 8'h06;
	localparam logic [7:0] OP_INC_DP = 8'ha3;
	localparam logic [7:0] OP_JB = 8'h20;
	localparam logic [7:0] OP_JNC = 8'h50;
	localparam logic [7:0] OP_JNZ = 8'h70;
	localparam logic [7:0] OP_JZ = 8'h60;
	localparam logic [7:0] OP_LONG_CALL = 8'h12;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [5:0] TIMER_RST = 6'h00;
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_PTR = 6'b000010,
		S_READ = 6'b000100,
		S_EXEC = 6'b001000,
		S_PUSH = 6'b010000,
		S_WAIT = 6'b100000
	} libce_state_e;
endpackage

/* File: design/libce_rel_adder.sv */
// Next-address and relative-target adder for the execution block.
// Purely combinational; caller presents the instruction start address.
`timescale 1ns/1ps
module libce_rel_adder
	import libce_pkg::*;
(
	input wire logic [15:0] base,
	input wire logic [1:0] len,
	input wire logic [7:0] rel,
	output logic [15:0] seq,
	output logic [15:0] target
);
	// Sixteen-bit sums drop the carry on purpose: wraps the 64K space
	assign seq = base + {14'h0000, len};
	assign target = seq + {{8{rel[7]}}, rel};
endmodule

/* File: design/libce_mcycle_timer.sv */
// Machine-cycle timer: paces an instruction to whole machine cycles.
// Loaded in the start cycle; expired is high in the last clock of it.
`timescale 1ns/1ps
module libce_mcycle_timer
	import libce_pkg::*;
#(
	parameter int CLKS = CLKS_PER_MCYCLE
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [1:0] mcycles,
	output logic expired
);
	logic [5:0] cnt;
	logic [5:0] total;

	// Minus two: one clock for the load itself, one for the final count
	assign total = 6'(32'(mcycles) * CLKS - 2);
	assign expired = (cnt == TIMER_RST);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt <= TIMER_RST;
		else if (load)
			cnt <= total;
		else if (cnt != TIMER_RST)
			cnt <= cnt - 6'h01;
	end
endmodule

/* File: design/libce_exec.sv */
// Execution unit for decrement-branch, increments, conditional jumps
// and the long call. Assumes the fetch path presents a whole instruction
// with start, and memory answers a read on the clock after rd_en/bit_en.
`timescale 1ns/1ps
module libce_exec
	import libce_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] byte2,
	input wire logic [7:0] byte3,
	input wire logic [15:0] pc_in,
	input wire logic [7:0] acc_in,
	input wire logic carry_in,
	input wire logic [7:0] sp_in,
	input wire logic [15:0] data_pointer_in,
	input wire logic [1:0] reg_bank,
	output logic rd_en,
	output logic [7:0] rd_addr,
	output logic rd_latch,
	input wire logic [7:0] rd_data,
	output logic bit_en,
	output logic [7:0] bit_addr,
	input wire logic bit_data,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [15:0] pc_out,
	output logic pc_load,
	output logic [7:0] acc_out,
	output logic acc_load,
	output logic [7:0] sp_out,
	output logic sp_load,
	output logic [15:0] data_pointer_out,
	output logic data_pointer_load,
	output logic busy,
	output logic done,
	output logic bad_opcode
);
	libce_state_e state;
	libce_state_e next_state;
	logic [7:0] op_r;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [15:0] pc_r;
	logic [7:0] acc_r;
	logic carry_r;
	logic [7:0] sp_r;
	logic [15:0] data_pointer_r;
	logic [1:0] bank_r;
	logic [7:0] op_addr;

	////////////////////////////////////////////////////////////////////
	// Decode

	logic idle;
	logic [7:0] cur_op;
	logic d_decrement_branch_nonzero_r;
	logic d_decrement_branch_nonzero_d;
	logic d_decrement_branch_nonzero;
	logic d_inc_a;
	logic d_inc_r;
	logic d_inc_d;
	logic d_inc_i;
	logic d_inc_m;
	logic d_inc_dp;
	logic d_jb;
	logic d_jnc;
	logic d_jnz;
	logic d_jz;
	logic d_long_call;
	logic d_pcw;
	logic d_legal;
	logic d_read;
	logic [1:0] d_cycles;
	logic [1:0] d_len;

	assign idle = (state == S_IDLE);
	// Decode from the pins while idle so dispatch costs no extra clock
	assign cur_op = idle ? opcode : op_r;
	assign d_decrement_branch_nonzero_r = (cur_op & OPM_REG) == OP_DECREMENT_BRANCH_NONZERO_R;
	assign d_decrement_branch_nonzero_d = (cur_op == OP_DECREMENT_BRANCH_NONZERO_D);
	assign d_decrement_branch_nonzero = d_decrement_branch_nonzero_r | d_decrement_branch_nonzero_d;
	assign d_inc_a = (cur_op == OP_INC_A);
	assign d_inc_r = (cur_op & OPM_REG) == OP_INC_R;
	assign d_inc_d = (cur_op == OP_INC_D);
	assign d_inc_i = (cur_op & OPM_IND) == OP_INC_I;
	assign d_inc_m = d_inc_r | d_inc_d | d_inc_i;
	assign d_inc_dp = (cur_op == OP_INC_DP);
	assign d_jb = (cur_op == OP_JB);
	assign d_jnc = (cur_op == OP_JNC);
	assign d_jnz = (cur_op == OP_JNZ);
	assign d_jz = (cur_op == OP_JZ);
	assign d_long_call = (cur_op == OP_LONG_CALL);
	assign d_pcw = d_decrement_branch_nonzero | d_jb | d_jnc | d_jnz | d_jz | d_long_call;
	assign d_legal = d_pcw | d_inc_a | d_inc_m | d_inc_dp;
	assign d_read = d_decrement_branch_nonzero | d_inc_r | d_inc_d | d_jb;
	// Unknown opcodes burn one machine cycle and are flagged
	assign d_cycles = (d_pcw | d_inc_dp) ? CYC_TWO : CYC_ONE;
	assign d_len = (d_decrement_branch_nonzero_d | d_jb | d_long_call) ? LEN_THREE : LEN_TWO;

	////////////////////////////////////////////////////////////////////
	// Operand access

	logic [7:0] reg_addr;
	logic [7:0] ptr_addr;
	logic [7:0] read_addr;

	assign reg_addr = {3'h0, bank_r, op_r[2:0]};
	assign ptr_addr = {3'h0, bank_r, 2'h0, op_r[0]};
	// Indirect form: pointer value arrives on rd_data in the read state
	assign read_addr = d_inc_i ? rd_data : ((d_decrement_branch_nonzero_r | d_inc_r) ? reg_addr : b2);
	assign rd_en = (state == S_PTR) | ((state == S_READ) & ~d_jb);
	assign rd_addr = (state == S_PTR) ? ptr_addr : read_addr;
	// Only direct bytes can hit a port; read-modify-write uses the latch
	assign rd_latch = (state == S_READ) & (d_decrement_branch_nonzero_d | d_inc_d);
	assign bit_en = (state == S_READ) & d_jb;
	assign bit_addr = b2;

	////////////////////////////////////////////////////////////////////
	// Arithmetic and branch decision

	logic [7:0] res_dec;
	logic [7:0] res_inc;
	logic [15:0] seq_pc;
	logic [15:0] tgt_pc;
	logic [15:0] call_pc;
	logic [7:0] rel;
	logic taken;

	assign res_dec = rd_data - 8'h01;
	assign res_inc = rd_data + 8'h01;
	// Displacement is always the final byte of the instruction
	assign rel = (d_decrement_branch_nonzero_d | d_jb) ? b3 : b2;
	assign call_pc = {b2, b3};
	assign taken = d_decrement_branch_nonzero ? (res_dec != BYTE_RST) :
		d_jb ? bit_data :
		d_jnc ? ~carry_r :
		d_jnz ? (acc_r != BYTE_RST) :
		d_jz & (acc_r == BYTE_RST);

	libce_rel_adder u_rel
	(
		.base(pc_r),
		.len(d_len),
		.rel(rel),
		.seq(seq_pc),
		.target(tgt_pc)
	);

	logic expired;

	libce_mcycle_timer u_timer
	(
		.clk(clk),
		.rst_n(rst_n),
		.load(idle & start),
		.mcycles(d_cycles),
		.expired(expired)
	);

	////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb
	begin
		next_state = state;
		unique case (state)
			S_IDLE:
				if (start)
					next_state = d_inc_i ? S_PTR : (d_read ? S_READ : S_EXEC);
			S_PTR:
				next_state = S_READ;
			S_READ:
				next_state = S_EXEC;
			S_EXEC:
				next_state = d_long_call ? S_PUSH : S_WAIT;
			S_PUSH:
				next_state = S_WAIT;
			S_WAIT:
				if (expired)
					next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	// Instruction capture; a start while busy is ignored
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			op_r <= BYTE_RST;
			b2 <= BYTE_RST;
			b3 <= BYTE_RST;
			pc_r <= WORD_RST;
			acc_r <= BYTE_RST;
			carry_r <= 1'b0;
			sp_r <= BYTE_RST;
			data_pointer_r <= WORD_RST;
			bank_r <= 2'h0;
		end
		else if (idle & start)
		begin
			op_r <= opcode;
			b2 <= byte2;
			b3 <= byte3;
			pc_r <= pc_in;
			acc_r <= acc_in;
			carry_r <= carry_in;
			sp_r <= sp_in;
			data_pointer_r <= data_pointer_in;
			bank_r <= reg_bank;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			op_addr <= BYTE_RST;
		else if (state == S_READ)
			op_addr <= read_addr;
	end

	////////////////////////////////////////////////////////////////////
	// Results; no flag output exists, so no flag can change

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pc_out <= WORD_RST;
			acc_out <= BYTE_RST;
			data_pointer_out <= WORD_RST;
			sp_out <= BYTE_RST;
		end
		else if (state == S_EXEC)
		begin
			pc_out <= d_long_call ? call_pc : (taken ? tgt_pc : seq_pc);
			acc_out <= acc_r + 8'h01;
			data_pointer_out <= data_pointer_r + 16'h0001;
			sp_out <= sp_r + 8'h02;
		end
	end

	// Writes: operand write-back, or the two stack pushes of a call
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_en <= 1'b0;
			wr_addr <= BYTE_RST;
			wr_data <= BYTE_RST;
		end
		else if (state == S_EXEC)
		begin
			wr_en <= d_decrement_branch_nonzero | d_inc_m | d_long_call;
			wr_addr <= d_long_call ? sp_r + 8'h01 : op_addr;
			wr_data <= d_long_call ? seq_pc[7:0] : (d_decrement_branch_nonzero ? res_dec : res_inc);
		end
		else if (state == S_PUSH)
		begin
			wr_en <= 1'b1;
			wr_addr <= sp_r + 8'h02;
			wr_data <= seq_pc[15:8];
		end
		else
			wr_en <= 1'b0;
	end

	assign busy = ~idle;
	assign done = (state == S_WAIT) & expired;
	assign pc_load = done & d_pcw;
	assign acc_load = done & d_inc_a;
	assign data_pointer_load = done & d_inc_dp;
	assign sp_load = done & d_long_call;
	assign bad_opcode = done & ~d_legal;

	////////////////////////////////////////////////////////////////////
	// Checks

	logic [5:0] elapsed;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			elapsed <= TIMER_RST;
		else if (idle & start)
			elapsed <= 6'h01;
		else if (~idle)
			elapsed <= elapsed + 6'h01;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence push_lo_s;
		wr_en && wr_addr == sp_r + 8'h01 && wr_data == seq_pc[7:0];
	endsequence

	sequence push_hi_s;
		wr_en && wr_addr == sp_r + 8'h02 && wr_data == seq_pc[15:8];
	endsequence

	decrement_branch_nonzero_writeback_a: assert property (
		state == S_EXEC && d_decrement_branch_nonzero |=> wr_en && wr_data == $past(rd_data) - 8'h01)
		else $error("decrement result not written back");

	decrement_branch_nonzero_wrap_a: assert property (
		state == S_EXEC && d_decrement_branch_nonzero && rd_data == 8'h00 |=> wr_data == 8'hff ##[1:30] done
		&& pc_out == tgt_pc)
		else $error("zero operand did not wrap and branch");

	inc_wrap_a: assert property (
		state == S_EXEC && d_inc_m && rd_data == 8'hff |=> wr_en && wr_data == 8'h00)
		else $error("increment of all ones did not wrap");

	data_pointer_step_a: assert property (
		data_pointer_load |-> data_pointer_out == data_pointer_r + 16'h0001 && !acc_load && !pc_load)
		else $error("data pointer increment wrong");

	call_push_a: assert property (
		state == S_EXEC && d_long_call |=> push_lo_s ##1 push_hi_s ##[1:30] sp_load
		&& sp_out == sp_r + 8'h02)
		else $error("call push sequence wrong");

	call_target_a: assert property (
		done && d_long_call |-> pc_load && pc_out == {b2, b3})
		else $error("call target wrong");

	instr_timing_a: assert property (
		done |-> elapsed == 6'(32'(d_cycles) * CLKS_PER_MCYCLE - 1))
		else $error("instruction did not take its machine cycles");

	port_latch_a: assert property (
		rd_en && state == S_READ && (d_decrement_branch_nonzero_d || d_inc_d) |-> rd_latch)
		else $error("port operand not read from latch");

	acc_branch_a: assert property (
		done && (d_jz || d_jnz) |-> !acc_load
		&& pc_out == (((acc_r == 8'h00) == d_jz) ? tgt_pc : seq_pc))
		else $error("accumulator branch wrong");

	carry_branch_a: assert property (
		done && d_jnc |-> pc_out == (carry_r ? seq_pc : tgt_pc))
		else $error("carry-clear branch wrong");
endmodule

/* File: bench/libce_mem_model.sv */
// Internal RAM, port latches and bit space facing the execution block.
// Assumes one-clock read latency; port pins read as the latch inverted.
`timescale 1ns/1ps
module libce_mem_model
(
	input wire logic clk,
	input wire logic rd_en,
	input wire logic [7:0] rd_addr,
	input wire logic rd_latch,
	output logic [7:0] rd_data,
	input wire logic bit_en,
	input wire logic [7:0] bit_addr,
	output logic bit_data,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data
);
////////////////////////////////
logic [7:0] ram [0:256-1];
wire logic is_port = rd_addr[7:6] == 2'h2 && rd_addr[3:0] == 4'h0;
wire logic [7:0] bit_byte = bit_addr[7] ? {bit_addr[7:3], 3'h0} : 8'h20 + {4'h0, bit_addr[6:3]};
initial rd_data = 8'h00;
initial bit_data = 1'b0;
// Idle lines toggle so a stale sample never looks valid
always @(posedge clk)
begin
	if (wr_en)
		ram[wr_addr] <= wr_data;
	// Pins differ from latch, so a wrong source shows
	rd_data <= rd_en ? (is_port && !rd_latch ? ~ram[rd_addr] : ram[rd_addr]) : ~rd_data;
	bit_data <= bit_en ? ram[bit_byte][bit_addr[2:0]] : ~bit_data;
end
endmodule

/* File: bench/libce_exec_test.sv */
// Self-checking bench for the execution block and its RAM model.
// Assumes 20 MHz clock and synchronous active-low reset.
`timescale 1ns/1ps
module libce_exec_test
	import libce_pkg::*;
;
////////////////////////////////
logic clk, rst_n, start, carry_in, cy, intrude;
logic [7:0] opcode, byte2, byte3, acc_in, sp_in, acc, sp, v, rl, a;
logic [15:0] pc_in, data_pointer_in, pc, dp;
logic [1:0] reg_bank, bank;
logic [2:0] r;
logic rd_en, rd_latch, bit_en, bit_data, wr_en, pc_load, acc_load, sp_load, data_pointer_load;
logic busy, done, bad_opcode;
logic [7:0] rd_addr, rd_data, bit_addr, wr_addr, wr_data, acc_out, sp_out;
logic [15:0] pc_out, data_pointer_out;
int errors, n_tests;
typedef struct packed {logic pl; logic [15:0] pc; logic al; logic [7:0] a;
	logic dl; logic [15:0] dp; logic sl; logic [7:0] sp; logic bad;} libce_note_s;
libce_note_s notes[$];
libce_note_s e;
libce_exec dut (.clk, .rst_n, .start, .opcode, .byte2, .byte3, .pc_in, .acc_in, .carry_in,
	.sp_in, .data_pointer_in, .reg_bank, .rd_en, .rd_addr, .rd_latch, .rd_data, .bit_en, .bit_addr,
	.bit_data, .wr_en, .wr_addr, .wr_data, .pc_out, .pc_load, .acc_out, .acc_load, .sp_out,
	.sp_load, .data_pointer_out, .data_pointer_load, .busy, .done, .bad_opcode);
libce_mem_model mem (.clk, .rd_en, .rd_addr, .rd_latch, .rd_data, .bit_en, .bit_addr,
	.bit_data, .wr_en, .wr_addr, .wr_data);
////////////////////////////////
initial
begin
	clk = 1'b0;
	forever #25 clk = ~clk;
end
task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
	n_tests++;
	if (got !== exp)
	begin
		errors++;
		$display("ERROR %0t %s got %h want %h", $time, what, got, exp);
	end
endtask
task automatic note(input logic pl, input logic [15:0] p, input logic al, input logic [7:0] x,
	input logic dl, input logic [15:0] d, input logic sl, input logic [7:0] s, input logic b);
	notes.push_back('{pl, p, al, x, dl, d, sl, s, b});
endtask
task automatic jmp(input logic [15:0] p);
	note(1'b1, p, 1'b0, 8'h00, 1'b0, 16'h0, 1'b0, 8'h00, 1'b0);
endtask
function automatic logic [15:0] tgt(input logic [15:0] p, input logic [7:0] x);
	return p + {{8{x[7]}}, x};
endfunction
task close_out;
	$display("errors=%0d n_tests=%0d", errors, n_tests);
	if (errors == 0 && n_tests > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
// Cycle count is taken from the start edge; a stray start mid-run must be ignored
task automatic go(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3, input int n);
	int k;
	@(posedge clk);
	{pc_in, acc_in, carry_in, sp_in, data_pointer_in, reg_bank} <= {pc, acc, cy, sp, dp, bank};
	{opcode, byte2, byte3, start} <= {op, b2, b3, 1'b1};
	@(posedge clk);
	start <= 1'b0;
	@(negedge clk);
	k = 1;
	while (k < 30 && done !== 1'b1)
	begin
		@(negedge clk);
		k++;
		if (intrude && k == 3)
		begin
			@(posedge clk);
			{opcode, start} <= {OP_INC_A, 1'b1};
			@(posedge clk);
			start <= 1'b0;
			k++;
		end
	end
	chk(16'(k), 16'(12 * n - 1), "cycles");
endtask
////////////////////////////////
always @(negedge clk)
	if (rst_n && done === 1'b1)
	begin
		if (notes.size() == 0)
			chk(16'h1, 16'h0, "extra done");
		else
		begin
			e = notes.pop_front();
			chk({11'h0, pc_load, acc_load, data_pointer_load, sp_load, bad_opcode},
				{11'h0, e.pl, e.al, e.dl, e.sl, e.bad}, "loads");
			if (e.pl)
				chk(pc_out, e.pc, "pc");
			if (e.al)
				chk({8'h0, acc_out}, {8'h0, e.a}, "acc");
			if (e.dl)
				chk(data_pointer_out, e.dp, "data_pointer");
			if (e.sl)
				chk({8'h0, sp_out}, {8'h0, e.sp}, "sp");
		end
	end
initial
begin
	repeat (5000) @(posedge clk);
	chk(16'h1, 16'h0, "timeout");
	close_out;
end
initial
begin
	{rst_n, start, carry_in, opcode, byte2, byte3, acc_in, sp_in} = '0;
	{pc_in, data_pointer_in, reg_bank, cy, acc, sp, pc, dp, bank, intrude} = '0;
	void'($urandom(57));
	repeat (20) @(posedge clk);
	rst_n <= 1'b1;
	for (int i = 0; i < 6; i++)
	begin
		v = i == 0 ? 8'h01 : i == 1 ? 8'h00 : 8'($urandom);
		{r, bank, pc, rl} = {3'($urandom), 2'($urandom), 16'($urandom), 8'($urandom)};
		a = {3'h0, bank, r};
		mem.ram[a] = v;
		jmp(v != 8'h01 ? tgt(pc + 16'h2, rl) : pc + 16'h2);
		go(OP_DECREMENT_BRANCH_NONZERO_R | {5'h0, r}, rl, 8'h00, 2);
		chk({8'h0, mem.ram[a]}, {8'h0, v - 8'h1}, "decrement_branch_nonzero reg");
	end
	// Port operand: latch 01 ends at zero, pins would branch
	for (int i = 0; i < 2; i++)
	begin
		{a, v, pc, rl} = {i ? 8'h40 : 8'h90, i ? 8'h70 : 8'h01, 16'hfffe, 8'h10};
		mem.ram[a] = v;
		jmp(i ? tgt(pc + 16'h3, rl) : pc + 16'h3);
		go(OP_DECREMENT_BRANCH_NONZERO_D, a, rl, 2);
		chk({8'h0, mem.ram[a]}, {8'h0, v - 8'h1}, "decrement_branch_nonzero dir");
	end
	acc = 8'hff;
	note(1'b0, 16'h0, 1'b1, 8'h00, 1'b0, 16'h0, 1'b0, 8'h00, 1'b0);
	go(OP_INC_A, 8'h00, 8'h00, 1);
	for (int i = 0; i < 3; i++)
	begin
		{r, bank} = {3'($urandom), 2'($urandom)};
		a = i == 0 ? {3'h0, bank, r} : i == 1 ? 8'ha0 : 8'h7e;
		mem.ram[{3'h0, bank, 3'h1}] = 8'h7e;
		mem.ram[a] = i == 1 ? 8'h7f : 8'hff;
		note(1'b0, 16'h0, 1'b0, 8'h00, 1'b0, 16'h0, 1'b0, 8'h00, 1'b0);
		go(i == 0 ? OP_INC_R | {5'h0, r} : i == 1 ? OP_INC_D : OP_INC_I | 8'h01, a, 8'h00, 1);
		chk({8'h0, mem.ram[a]}, i == 1 ? 16'h0080 : 16'h0000, "inc");
	end
	dp = 16'h12fe;
	for (int i = 0; i < 4; i++)
	begin
		note(1'b0, 16'h0, 1'b0, 8'h00, 1'b1, dp + 16'h1, 1'b0, 8'h00, 1'b0);
		go(OP_INC_DP, 8'h00, 8'h00, 2);
		dp = i == 2 ? 16'hffff : dp + 16'h1;
	end
	for (int i = 0; i < 2; i++)
	begin
		{pc, rl} = {16'h0100, 8'h80};
		mem.ram[8'h22] = i ? 8'h04 : 8'hfb;
		jmp(i ? tgt(pc + 16'h3, rl) : pc + 16'h3);
		go(OP_JB, 8'h12, rl, 2);
		chk({8'h0, mem.ram[8'h22]}, i ? 16'h0004 : 16'h00fb, "bit");
	end
	for (int i = 0; i < 8; i++)
	begin
		acc = i == 0 ? 8'h00 : i == 1 ? 8'h80 : 8'($urandom);
		{cy, pc, rl} = {i[0], 16'($urandom), 8'($urandom)};
		jmp(cy ? pc + 16'h2 : tgt(pc + 16'h2, rl));
		go(OP_JNC, rl, 8'h00, 2);
		jmp(acc != 8'h00 ? tgt(pc + 16'h2, rl) : pc + 16'h2);
		go(OP_JNZ, rl, 8'h00, 2);
		jmp(acc == 8'h00 ? tgt(pc + 16'h2, rl) : pc + 16'h2);
		go(OP_JZ, rl, 8'h00, 2);
	end
	for (int i = 0; i < 2; i++)
	begin
		{sp, pc, intrude} = {i ? 8'hfe : 8'h07, i ? 16'hfffe : 16'h0123, i == 0};
		note(1'b1, 16'h1234, 1'b0, 8'h00, 1'b0, 16'h0, 1'b1, sp + 8'h2, 1'b0);
		go(OP_LONG_CALL, 8'h12, 8'h34, 2);
		chk({mem.ram[sp + 8'h2], mem.ram[sp + 8'h1]}, pc + 16'h3, "stack");
	end
	intrude = 1'b0;
	note(1'b0, 16'h0, 1'b0, 8'h00, 1'b0, 16'h0, 1'b0, 8'h00, 1'b1);
	go(8'hff, 8'h00, 8'h00, 1);
	repeat (30) @(posedge clk);
	close_out;
end
endmodule
